// [design/svi_pkg.sv]
package svi_pkg;

    // Register offsets on the special function register port.
    localparam logic [8:0] OFS_EN_MAIN = 9'h00b;
    localparam logic [8:0] OFS_PEND_MAIN = 9'h00c;
    localparam logic [8:0] OFS_EN_AUX = 9'h00d;
    localparam logic [8:0] OFS_PEND_AUX = 9'h00e;
    localparam logic [8:0] OFS_OPTION = 9'h081;

    // Bit positions in the main enable and pending registers.
    localparam int BIT_CONV = 7;
    localparam int BIT_TIMER_B = 5;
    localparam int BIT_TIMER_A = 4;
    localparam int BIT_WAKE = 3;
    localparam int BIT_PIN_C = 2;
    localparam int BIT_PIN_B = 1;
    localparam int BIT_PIN_A = 0;

    // Bit positions in the auxiliary enable and pending registers.
    localparam int BIT_PIN_CHANGE = 6;
    localparam int BIT_PULSE = 1;
    localparam int BIT_LOW_VOLT = 0;

    // Edge select bits in the option register.
    localparam int BIT_EDGE_A = 6;
    localparam int BIT_EDGE_B = 5;

    // Implemented bits of each register; others read as zero.
    localparam logic [7:0] MASK_MAIN = 8'hbf;
    localparam logic [7:0] MASK_AUX = 8'h43;
    localparam logic [7:0] MASK_OPTION = 8'hef;

    // Reset values.
    localparam logic [7:0] RST_EN = 8'h00;
    localparam logic [7:0] RST_PEND = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'h0f;

    // Common service vector and the inserted long call.
    localparam logic [11:0] SERVICE_VECTOR = 12'h004;

    // Source count, unused; set to 9 while the unit has ten sources.
    localparam int NUM_SRC = 9;

    // Service state of the unit.
    typedef enum logic [1:0] {
        SVC_IDLE = 2'b00,
        SVC_ACTIVE = 2'b01,
        SVC_RETURN = 2'b10
    } svi_svc_e;

    // Hardware event strobes from the peripherals, one cycle each.
    typedef struct packed {
        logic conv_done;
        logic timer_b_ovf;
        logic timer_a_ovf;
        logic wake_timeout;
        logic pulse_rollover;
        logic low_voltage;
    } svi_evt_s;

    // Register bus request.
    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } svi_bus_s;

    // Instruction sequencer handshake.
    typedef struct packed {
        logic instr_end;
        logic return_done;
    } svi_cpu_s;

    // Whole state of the unit.
    typedef struct packed {
        logic [7:0] en_main;
        logic [7:0] pend_main;
        logic [7:0] en_aux;
        logic [7:0] pend_aux;
        logic [7:0] option;
        logic [7:0] rdata;
        logic [2:0] pin_sync1;
        logic [2:0] pin_sync2;
        logic [2:0] pin_prev;
        logic [7:0] port_sync1;
        logic [7:0] port_sync2;
        logic [7:0] port_prev;
        svi_svc_e svc;
        logic insert_call;
    } svi_state_s;

endpackage

// [design/svi_unit.sv]
module svi_unit #(
    parameter int PORT_W = 8
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic NRST,
    // Register port.
    input wire svi_pkg::svi_bus_s BUS,
    output logic [7:0] RDATA,
    // Peripheral event strobes, same clock.
    input wire svi_pkg::svi_evt_s EVT,
    // Asynchronous pins.
    input wire logic [2:0] EXT_PIN,
    input wire logic [PORT_W-1:0] PORT_PIN,
    // Instruction sequencer.
    input wire svi_pkg::svi_cpu_s CPU,
    output logic SERVICE_REQ,
    output logic INSERT_CALL,
    output logic [11:0] CALL_TARGET,
    output logic IN_SERVICE,
    // Wake timer control.
    output logic WAKE_TIMER_RUN,
    output logic WAKE_TIMER_CLEAR
);
    import svi_pkg::*;

    svi_state_s st_r;
    svi_state_s st_nxt;
    logic [7:0] rd_mux;
    logic [2:0] pin_fall;
    logic [2:0] pin_rise;
    logic port_edge;
    logic any_req;
    logic [7:0] set_main;
    logic [7:0] set_aux;

    // Edge detection reads only the second synchroniser stage and its delayed copy.
    assign pin_fall = st_r.pin_prev & ~st_r.pin_sync2;
    assign pin_rise = ~st_r.pin_prev & st_r.pin_sync2;
    assign port_edge = |(st_r.port_prev[PORT_W-1:0] ^ st_r.port_sync2[PORT_W-1:0]);

    // Request is the OR of every enabled pending flag; stays while any enabled flag stays set.
    assign any_req = |(st_r.pend_main & st_r.en_main & MASK_MAIN)
        | |(st_r.pend_aux & st_r.en_aux & MASK_AUX);

    // Hardware set terms for each flag.
    always_comb
    begin
        set_main = 8'h00;
        set_aux = 8'h00;
        set_main[BIT_CONV] = EVT.conv_done;
        set_main[BIT_TIMER_B] = EVT.timer_b_ovf;
        set_main[BIT_TIMER_A] = EVT.timer_a_ovf;
        set_main[BIT_WAKE] = EVT.wake_timeout && st_r.en_main[BIT_WAKE];
        set_main[BIT_PIN_C] = pin_fall[2];
        set_main[BIT_PIN_B] = st_r.option[BIT_EDGE_B] ? pin_rise[1] : pin_fall[1];
        set_main[BIT_PIN_A] = st_r.option[BIT_EDGE_A] ? pin_rise[0] : pin_fall[0];
        set_aux[BIT_PIN_CHANGE] = port_edge;
        set_aux[BIT_PULSE] = EVT.pulse_rollover;
        set_aux[BIT_LOW_VOLT] = EVT.low_voltage;
    end

    // Read mux; unmapped addresses read zero.
    always_comb
    begin
        if (BUS.addr == OFS_EN_MAIN)
            rd_mux = st_r.en_main;
        else if (BUS.addr == OFS_PEND_MAIN)
            rd_mux = st_r.pend_main;
        else if (BUS.addr == OFS_EN_AUX)
            rd_mux = st_r.en_aux;
        else if (BUS.addr == OFS_PEND_AUX)
            rd_mux = st_r.pend_aux;
        else if (BUS.addr == OFS_OPTION)
            rd_mux = st_r.option;
        else
            rd_mux = 8'h00;
    end

    // Next state of the whole unit.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pin_sync1 = EXT_PIN;
        st_nxt.pin_sync2 = st_r.pin_sync1;
        st_nxt.pin_prev = st_r.pin_sync2;
        st_nxt.port_sync1 = 8'h00;
        st_nxt.port_sync1[PORT_W-1:0] = PORT_PIN;
        st_nxt.port_sync2 = st_r.port_sync1;
        st_nxt.port_prev = st_r.port_sync2;
        st_nxt.insert_call = 1'b0;
        st_nxt.rdata = BUS.rd ? rd_mux : 8'h00;

        // Register writes; pending flags only clear where a zero is written.
        if (BUS.wr)
        begin
            if (BUS.addr == OFS_EN_MAIN)
                st_nxt.en_main = BUS.wdata & MASK_MAIN;
            else if (BUS.addr == OFS_PEND_MAIN)
                st_nxt.pend_main = st_r.pend_main & BUS.wdata;
            else if (BUS.addr == OFS_EN_AUX)
                st_nxt.en_aux = BUS.wdata & MASK_AUX;
            else if (BUS.addr == OFS_PEND_AUX)
                st_nxt.pend_aux = st_r.pend_aux & BUS.wdata;
            else if (BUS.addr == OFS_OPTION)
                st_nxt.option = BUS.wdata & MASK_OPTION;
        end

        // Sets are applied after the clear so a coincident event is never lost.
        st_nxt.pend_main = (st_nxt.pend_main | set_main) & MASK_MAIN;
        st_nxt.pend_aux = (st_nxt.pend_aux | set_aux) & MASK_AUX;

        // Service sequencing. The flag stays up through the instruction after return.
        case (st_r.svc)
            SVC_IDLE:
            begin
                if (any_req && CPU.instr_end)
                begin
                    st_nxt.insert_call = 1'b1;
                    st_nxt.svc = SVC_ACTIVE;
                end
            end
            SVC_ACTIVE:
            begin
                if (CPU.return_done)
                    st_nxt.svc = SVC_RETURN;
            end
            SVC_RETURN:
            begin
                if (CPU.instr_end)
                    st_nxt.svc = SVC_IDLE;
            end
            default:
                st_nxt.svc = SVC_IDLE;
        endcase
    end

    // State register with synchronous reset.
    always_ff @(posedge CLK)
    begin
        if (!NRST)
        begin
            st_r <= '0;
            st_r.en_main <= RST_EN;
            st_r.en_aux <= RST_EN;
            st_r.pend_main <= RST_PEND;
            st_r.pend_aux <= RST_PEND;
            st_r.option <= RST_OPTION;
            st_r.svc <= SVC_IDLE;
            // Synchronisers keep following the pins through reset, so release brings no false edge.
            st_r.pin_sync1 <= st_nxt.pin_sync1;
            st_r.pin_sync2 <= st_nxt.pin_sync2;
            st_r.pin_prev <= st_nxt.pin_prev;
            st_r.port_sync1 <= st_nxt.port_sync1;
            st_r.port_sync2 <= st_nxt.port_sync2;
            st_r.port_prev <= st_nxt.port_prev;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs. The request is masked while in service so the core cannot nest.
    assign RDATA = st_r.rdata;
    assign IN_SERVICE = (st_r.svc != SVC_IDLE);
    assign SERVICE_REQ = any_req && !IN_SERVICE;
    assign INSERT_CALL = st_r.insert_call;
    assign CALL_TARGET = SERVICE_VECTOR;
    assign WAKE_TIMER_RUN = st_r.en_main[BIT_WAKE];
    assign WAKE_TIMER_CLEAR = !st_r.en_main[BIT_WAKE];

    // Checks.
    property p_pend_sticky;
        @(posedge CLK) disable iff (!NRST)
        (EVT.conv_done) |=> st_r.pend_main[BIT_CONV];
    endproperty
    a_pend_sticky: assert property (p_pend_sticky) else $error("conv flag not set");

    property p_set_wins;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_PEND_AUX && EVT.low_voltage) |=> st_r.pend_aux[BIT_LOW_VOLT];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

    property p_accept;
        @(posedge CLK) disable iff (!NRST)
        (SERVICE_REQ && CPU.instr_end) |=> INSERT_CALL && IN_SERVICE;
    endproperty
    a_accept: assert property (p_accept) else $error("request not accepted");

    property p_only_end;
        @(posedge CLK) disable iff (!NRST)
        INSERT_CALL |-> $past(CPU.instr_end) && !$past(IN_SERVICE);
    endproperty
    a_only_end: assert property (p_only_end) else $error("call mid instruction");

    property p_no_nest;
        @(posedge CLK) disable iff (!NRST)
        IN_SERVICE |=> !INSERT_CALL;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("call while in service");

    property p_hold_after_ret;
        @(posedge CLK) disable iff (!NRST)
        (st_r.svc == SVC_ACTIVE && CPU.return_done) |=> IN_SERVICE;
    endproperty
    a_hold_after_ret: assert property (p_hold_after_ret) else $error("flag dropped early");

    property p_level;
        @(posedge CLK) disable iff (!NRST)
        (st_r.pend_main[BIT_TIMER_A] && st_r.en_main[BIT_TIMER_A] && !IN_SERVICE)
            |-> SERVICE_REQ;
    endproperty
    a_level: assert property (p_level) else $error("enabled flag not requesting");

    property p_write_one;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_PEND_MAIN && set_main == 8'h00)
            |=> st_r.pend_main == ($past(st_r.pend_main) & $past(BUS.wdata));
    endproperty
    a_write_one: assert property (p_write_one) else $error("pending write not a clear");

    property p_wake_stop;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_EN_MAIN && !BUS.wdata[BIT_WAKE])
            |=> WAKE_TIMER_CLEAR && !WAKE_TIMER_RUN;
    endproperty
    a_wake_stop: assert property (p_wake_stop) else $error("wake timer runs disabled");

    property p_read_lat;
        @(posedge CLK) disable iff (!NRST)
        (BUS.rd && BUS.addr == OFS_OPTION) |=> RDATA == $past(st_r.option);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data wrong");

    // Each hardware event leaves its flag set in the next cycle, enabled or not, except the wake timeout, which sets its flag only while enabled.
    property p_timer_b_set;
        @(posedge CLK) disable iff (!NRST)
        EVT.timer_b_ovf |=> st_r.pend_main[BIT_TIMER_B];
    endproperty
    a_timer_b_set: assert property (p_timer_b_set) else $error("timer b flag not set");

    property p_timer_a_set;
        @(posedge CLK) disable iff (!NRST)
        EVT.timer_a_ovf |=> st_r.pend_main[BIT_TIMER_A];
    endproperty
    a_timer_a_set: assert property (p_timer_a_set) else $error("timer a flag not set");

    property p_wake_set;
        @(posedge CLK) disable iff (!NRST)
        (EVT.wake_timeout && st_r.en_main[BIT_WAKE]) |=> st_r.pend_main[BIT_WAKE];
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag not set");

    property p_pulse_set;
        @(posedge CLK) disable iff (!NRST)
        EVT.pulse_rollover |=> st_r.pend_aux[BIT_PULSE];
    endproperty
    a_pulse_set: assert property (p_pulse_set) else $error("pulse flag not set");

    property p_low_volt_set;
        @(posedge CLK) disable iff (!NRST)
        EVT.low_voltage |=> st_r.pend_aux[BIT_LOW_VOLT];
    endproperty
    a_low_volt_set: assert property (p_low_volt_set) else $error("low voltage flag not set");

    // Pin edges are judged on the second synchroniser stage and its delayed copy.
    property p_pin_c_fall;
        @(posedge CLK) disable iff (!NRST)
        (st_r.pin_prev[2] && !st_r.pin_sync2[2]) |=> st_r.pend_main[BIT_PIN_C];
    endproperty
    a_pin_c_fall: assert property (p_pin_c_fall) else $error("pin c fall missed");

    property p_pin_c_only_fall;
        @(posedge CLK) disable iff (!NRST)
        (!st_r.pend_main[BIT_PIN_C] && !(st_r.pin_prev[2] && !st_r.pin_sync2[2]))
            |=> !st_r.pend_main[BIT_PIN_C];
    endproperty
    a_pin_c_only_fall: assert property (p_pin_c_only_fall) else $error("pin c set on rise");

    property p_pin_a_edge;
        @(posedge CLK) disable iff (!NRST)
        (st_r.option[BIT_EDGE_A] ? (!st_r.pin_prev[0] && st_r.pin_sync2[0])
            : (st_r.pin_prev[0] && !st_r.pin_sync2[0])) |=> st_r.pend_main[BIT_PIN_A];
    endproperty
    a_pin_a_edge: assert property (p_pin_a_edge) else $error("pin a edge missed");

    property p_pin_b_edge;
        @(posedge CLK) disable iff (!NRST)
        (st_r.option[BIT_EDGE_B] ? (!st_r.pin_prev[1] && st_r.pin_sync2[1])
            : (st_r.pin_prev[1] && !st_r.pin_sync2[1])) |=> st_r.pend_main[BIT_PIN_B];
    endproperty
    a_pin_b_edge: assert property (p_pin_b_edge) else $error("pin b edge missed");

    property p_port_change;
        @(posedge CLK) disable iff (!NRST)
        (st_r.port_prev != st_r.port_sync2) |=> st_r.pend_aux[BIT_PIN_CHANGE];
    endproperty
    a_port_change: assert property (p_port_change) else $error("pin change missed");

    // Enable and option writes land as written, trimmed to the implemented bits; pending writes only clear.
    property p_en_main_wr;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_EN_MAIN) |=> st_r.en_main == ($past(BUS.wdata) & MASK_MAIN);
    endproperty
    a_en_main_wr: assert property (p_en_main_wr) else $error("main enable write wrong");

    property p_en_aux_wr;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_EN_AUX) |=> st_r.en_aux == ($past(BUS.wdata) & MASK_AUX);
    endproperty
    a_en_aux_wr: assert property (p_en_aux_wr) else $error("aux enable write wrong");

    property p_option_wr;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_OPTION) |=> st_r.option == ($past(BUS.wdata) & MASK_OPTION);
    endproperty
    a_option_wr: assert property (p_option_wr) else $error("option write wrong");

    property p_aux_clear;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_PEND_AUX && set_aux == 8'h00)
            |=> st_r.pend_aux == ($past(st_r.pend_aux) & $past(BUS.wdata));
    endproperty
    a_aux_clear: assert property (p_aux_clear) else $error("aux pending write wrong");

    property p_unused_zero;
        @(posedge CLK) disable iff (!NRST)
        ((st_r.en_main | st_r.pend_main) & ~MASK_MAIN) == 8'h00
            && ((st_r.en_aux | st_r.pend_aux) & ~MASK_AUX) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_wake_run;
        @(posedge CLK) disable iff (!NRST)
        (BUS.wr && BUS.addr == OFS_EN_MAIN && BUS.wdata[BIT_WAKE])
            |=> WAKE_TIMER_RUN && !WAKE_TIMER_CLEAR;
    endproperty
    a_wake_run: assert property (p_wake_run) else $error("wake timer not started");

    // Service sequencing around the return, and the source behind each request.
    property p_ret_clear;
        @(posedge CLK) disable iff (!NRST)
        (st_r.svc == SVC_RETURN && CPU.instr_end) |=> !IN_SERVICE;
    endproperty
    a_ret_clear: assert property (p_ret_clear) else $error("in service not cleared");

    property p_req_source;
        @(posedge CLK) disable iff (!NRST)
        SERVICE_REQ |-> (|(st_r.pend_main & st_r.en_main) || |(st_r.pend_aux & st_r.en_aux));
    endproperty
    a_req_source: assert property (p_req_source) else $error("request without source");

    c_accept: cover property (@(posedge CLK) disable iff (!NRST) INSERT_CALL);
    c_return: cover property (@(posedge CLK) disable iff (!NRST)
        IN_SERVICE && CPU.return_done ##[1:20] !IN_SERVICE);
    c_retrigger: cover property (@(posedge CLK) disable iff (!NRST)
        $fell(IN_SERVICE) ##[1:20] INSERT_CALL);
    c_pin_change: cover property (@(posedge CLK) disable iff (!NRST) port_edge);
    c_set_vs_clear: cover property (@(posedge CLK) disable iff (!NRST)
        BUS.wr && BUS.addr == OFS_PEND_MAIN && set_main != 8'h00);
endmodule

// [verification/svi_cpu_model.sv]
module svi_cpu_model #(
    parameter int ROUTINE = 4
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Cycles per instruction less one; 3 stalls the core.
    input wire logic [1:0] pace,
    // Sequencer handshake.
    input wire logic insert_call,
    output svi_pkg::svi_cpu_s cpu
);
    timeunit 1ns;
    timeprecision 1ps;
    import svi_pkg::*;
    logic [1:0] cyc_r;
    int left_r;
    logic last;

    // An instruction ends once its cycle count reaches the pace.
    assign last = (pace != 2'd3) && (cyc_r >= pace);

    // The return ends with its own instruction, so reopening needs one more.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cyc_r <= 2'd0;
            left_r <= 0;
            cpu <= '0;
        end
        else
        begin
            cyc_r <= last ? 2'd0 : cyc_r + 2'd1;
            cpu.instr_end <= last;
            cpu.return_done <= last && (left_r == 1);
            if (insert_call)
                left_r <= ROUTINE;
            else if (last && left_r > 0)
                left_r <= left_r - 1;
        end
    end
endmodule

// [verification/svi_unit_tb.sv]
module svi_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import svi_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    svi_bus_s bus = '0;
    svi_evt_s evt = '0;
    logic [2:0] ext_pin = 3'h7;
    logic [7:0] port_pin = 8'h00;
    logic [1:0] pace = 2'd3;
    svi_cpu_s cpu;
    logic [7:0] rdata;
    logic svc_req, ins, in_svc, wk_run, wk_clr;
    logic [11:0] tgt;
    logic [15:0] acc;
    logic [8:0] a;
    logic [7:0] d;
    logic [8:0] addrs [6] = '{OFS_EN_MAIN, OFS_PEND_MAIN, OFS_EN_AUX, OFS_PEND_AUX,
                              OFS_OPTION, 9'h0ff};
    logic [15:0] evt_map [6] = '{16'h0001, 16'h0002, 16'h0800, 16'h1000, 16'h2000, 16'h8000};
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int ends = 2;
    int n_ins = 0;
    logic prev_end = 1'b0;

    svi_unit dut (.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .EVT(evt),
        .EXT_PIN(ext_pin), .PORT_PIN(port_pin), .CPU(cpu), .SERVICE_REQ(svc_req),
        .INSERT_CALL(ins), .CALL_TARGET(tgt), .IN_SERVICE(in_svc),
        .WAKE_TIMER_RUN(wk_run), .WAKE_TIMER_CLEAR(wk_clr));
    svi_cpu_model cpu_model (.clk(clk), .nrst(nrst), .pace(pace), .insert_call(ins),
        .cpu(cpu));

    // Clock at 250 MHz.
    always #2 clk = ~clk;

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [8:0] ad, input logic [7:0] dt);
        @(posedge clk);
        bus <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [8:0] ad, input logic [7:0] e);
        @(posedge clk);
        bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check({4'h0, rdata}, {4'h0, e});
    endtask

    // Only implemented bits read back; pending writes can only clear.
    function automatic logic [7:0] exp_reg(input logic [8:0] ad, input logic [7:0] dt);
        case (ad)
            OFS_EN_MAIN: return dt & MASK_MAIN;
            OFS_EN_AUX: return dt & MASK_AUX;
            OFS_OPTION: return dt & MASK_OPTION;
            default: return 8'h00;
        endcase
    endfunction

    // Call handshake monitor and hang limit.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            finish_test();
        end
        if (ins === 1'b1)
        begin
            n_ins++;
            check(prev_end, 1'b1);
            check(ends >= 2, 1'b1);
            check(tgt, SERVICE_VECTOR);
        end
        if (cpu.return_done === 1'b1)
            ends = 0;
        else if (cpu.instr_end === 1'b1)
            ends++;
        prev_end = cpu.instr_end;
    end

    initial
    begin
        void'($urandom(32'h5797));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 5; k++)
            rd(addrs[k], (k == 4) ? 8'h0f : 8'h00);
        #1 check(wk_clr, 1'b1);
        // Random writes with the core stalled, so no call can be taken.
        for (int k = 0; k < 6; k++)
        begin
            a = addrs[k];
            d = 8'($urandom);
            wr(a, d);
            rd(a, exp_reg(a, d));
        end
        wr(OFS_EN_AUX, 8'h00);
        wr(OFS_OPTION, 8'h0f);
        wr(OFS_PEND_MAIN, 8'h00);
        wr(OFS_EN_MAIN, 8'h08);
        #1 check(wk_run, 1'b1);
        acc = 16'h0000;
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            evt <= svi_evt_s'(6'(1) << i);
            @(posedge clk);
            evt <= '0;
            acc = acc | evt_map[i];
            rd(OFS_PEND_MAIN, acc[15:8]);
            rd(OFS_PEND_AUX, acc[7:0]);
            check(svc_req, i >= 2);
        end
        check(12'(n_ins), 12'h000);
        // A set in the cycle of a clearing write wins; writing ones keeps.
        @(posedge clk);
        bus <= '{addr: OFS_PEND_MAIN, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        evt <= '{timer_a_ovf: 1'b1, default: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        evt <= '0;
        wr(OFS_PEND_MAIN, 8'hff);
        rd(OFS_PEND_MAIN, 8'h10);
        wr(OFS_EN_MAIN, 8'h00);
        #1 check(wk_clr, 1'b1);
        wr(OFS_PEND_MAIN, 8'h00);
        ext_pin <= 3'h0;
        repeat (5) @(posedge clk);
        rd(OFS_PEND_MAIN, 8'h07);
        wr(OFS_PEND_MAIN, 8'h00);
        wr(OFS_OPTION, 8'h6f);
        ext_pin <= 3'h7;
        repeat (5) @(posedge clk);
        rd(OFS_PEND_MAIN, 8'h03);
        wr(OFS_PEND_MAIN, 8'h00);
        ext_pin <= 3'h0;
        port_pin <= 8'($urandom) | 8'h01;
        repeat (5) @(posedge clk);
        rd(OFS_PEND_MAIN, 8'h04);
        // Low voltage and pulse flags from the event sweep are still set.
        rd(OFS_PEND_AUX, 8'h43);
        wr(OFS_PEND_MAIN, 8'h00);
        wr(OFS_PEND_AUX, 8'h00);
        // Service with a slow core; the first routine leaves its flag set.
        wr(OFS_EN_MAIN, 8'h10);
        pace <= 2'd2;
        @(posedge clk);
        evt <= '{timer_a_ovf: 1'b1, default: 1'b0};
        @(posedge clk);
        evt <= '0;
        #1 check(svc_req, 1'b1);
        while (n_ins < 1)
            @(posedge clk);
        #1 check(in_svc, 1'b1);
        check(svc_req, 1'b0);
        while (n_ins < 2)
            @(posedge clk);
        wr(OFS_PEND_MAIN, 8'hef);
        while (in_svc !== 1'b0)
            @(posedge clk);
        repeat (40) @(posedge clk);
        check(12'(n_ins), 12'h002);
        finish_test();
    end
endmodule
